// *** design/usb_ep_pkg.sv ***
// shared constants and types of the endpoint transaction handler
// assumes one clock for both ends, sie logic and apb on clock_i
// Operation
// - control: setup, data stage, opposite status
// - control transfers only on single-bank endpoints
// - isochronous only on dual-bank endpoints
// - stall answer aborts a control transfer
// - status in: zero-length packet with data1
// - status out: host sends empty data out
// - setup acked automatically, setup flag set
// - setup flag keeps gated interrupt pending
// - read setup payload before clearing flag
// - single bank: load only when ready clear
// - payload loaded byte by byte, zero allowed
// - ready flag hands bank to next in
// - host ack sets complete, interrupt pending
// - firmware clears complete every time
// - clear complete only after next ready; code also takes the clear without it when bit 0 marks the final packet
// - dual bank: one bank cpu, one usb
// - fill bank 1 while bank 0 waits
// - ready for bank 1 frees bank 0
// - in token with nothing ready gets nak
// - dual bank for high-bandwidth bulk
// - master clock plus 48 mhz usb clock
// - fifo moved by 8-bit register accesses
package usb_ep_pkg;

	// ------------------------------------------------------------
	// endpoint geometry
	// ------------------------------------------------------------
	localparam int         NUM_EP     = 4;
	localparam int         BANK_BYTES = 64;
	localparam int         MEM_DEPTH  = NUM_EP * 2 * BANK_BYTES;
	localparam logic [6:0] EP_SIZE [NUM_EP] = '{7'h08, 7'h40, 7'h40, 7'h40};
	localparam logic [3:0] DUAL_CAP   = 4'h6;

	// ------------------------------------------------------------
	// controller register map and command fields
	// ------------------------------------------------------------
	localparam logic [11:0] CMD_OFS   = 12'h000;
	localparam logic [11:0] STAT_OFS  = 12'h004;
	localparam logic [11:0] RDATA_OFS = 12'h008;
	localparam int          CMD_OP_LSB = 8;
	localparam int          CMD_EP_LSB = 12;
	localparam int          STAT_BUSY  = 16;
	localparam int          STAT_TXRDY = 17;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_FIFO_WR, OP_FIFO_RD, OP_SET_TXRDY, OP_CLR_TX_COMPLETE_FLAG,
		OP_CLR_SETUP_RECEIVED_FLAG, OP_SET_STALL, OP_CLR_STALL, OP_SET_CFG
	} op_e;
	typedef enum logic [1:0] {TOK_SETUP, TOK_OUT, TOK_IN} tok_e;
	typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_e;

endpackage : usb_ep_pkg

// *** design/ep_link_if.sv ***
// link between endpoint logic and its firmware-side controller
// assumes both ends clocked by the same clock_i
`timescale 1ns/100ps
interface ep_link_if;
	import usb_ep_pkg::*;
	logic        fw_valid;  // one-cycle command pulse
	op_e         fw_op;
	logic [1:0]  fw_ep;
	logic [7:0]  fw_wdata;
	logic        fw_rvalid; // one-cycle answer pulse
	logic        fw_ok;
	logic [7:0]  fw_rdata;
	logic [3:0]  st_txrdy;
	logic [3:0]  st_tx_complete_flag;
	logic [3:0]  st_setup_received_flag;
	logic [3:0]  st_irq;
	logic [3:0]  st_dual;

	modport dev_mp (
		input  fw_valid, fw_op, fw_ep, fw_wdata,
		output fw_rvalid, fw_ok, fw_rdata,
		output st_txrdy, st_tx_complete_flag, st_setup_received_flag, st_irq, st_dual
	);
	modport ctl_mp (
		output fw_valid, fw_op, fw_ep, fw_wdata,
		input  fw_rvalid, fw_ok, fw_rdata,
		input  st_txrdy, st_tx_complete_flag, st_setup_received_flag, st_irq, st_dual
	);
endinterface : ep_link_if

// *** design/ep_txn_dev.sv ***
// endpoint transaction logic: setup capture, data in banks, handshakes
// assumes a serial engine delivering decoded tokens and bytes on clock_i
`timescale 1ns/100ps
module ep_txn_dev (
	input  wire logic                 clock_i, // sole clock
	input  wire logic                 rst_i,
	ep_link_if.dev_mp                 link,
	input  wire logic                 tok_valid_i,
	input  wire usb_ep_pkg::tok_e     tok_type_i,
	input  wire logic [1:0]           tok_ep_i,
	input  wire logic                 rx_valid_i,
	input  wire logic [7:0]           rx_byte_i,
	input  wire logic                 rx_end_i,
	input  wire logic                 tx_ready_i,
	input  wire logic                 hs_in_valid_i,
	input  wire logic                 hs_in_ack_i,
	output logic                      tx_start_o,
	output logic                      tx_data1_o,
	output logic [6:0]                tx_len_o,
	output logic                      tx_valid_o,
	output logic [7:0]                tx_byte_o,
	output logic                      tx_last_o,
	output logic                      hs_valid_o,
	output usb_ep_pkg::hs_e           hs_code_o
);
	import usb_ep_pkg::*;

	typedef enum {S_IDLE, S_RX, S_TX, S_HS} usb_st_e;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	usb_st_e     st_q;
	logic [7:0]  mem_q [MEM_DEPTH];
	logic [1:0]  rdy_q [NUM_EP];
	logic [6:0]  cnt_q [NUM_EP][2];
	logic [5:0]  rdptr_q [NUM_EP];
	logic [3:0]  tx_complete_flag_q, setup_received_flag_q, stall_q, dual_q, irqen_q;
	logic [3:0]  tog_q, fwbank_q, usbbank_q;
	logic [1:0]  cur_ep_q;
	logic        cur_bank_q, is_setup_q;
	logic [6:0]  idx_q;
	logic        fw_rvalid_q, fw_ok_q;
	logic [7:0]  fw_rdata_q;
	logic [3:0]  st_txrdy_q, st_irq_q;

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	logic       wb, rx_we, setup_done, in_ack, fw_wr_ok, fw_ok_d;
	logic [1:0] fe;
	logic [6:0] cur_len;

	assign fe         = link.fw_ep;
	assign wb         = dual_q[fe] & fwbank_q[fe];
	assign cur_len    = cnt_q[cur_ep_q][cur_bank_q];
	assign rx_we      = st_q == S_RX && rx_valid_i &&
	                    idx_q < EP_SIZE[cur_ep_q];
	assign setup_done = st_q == S_RX && rx_end_i && is_setup_q;
	assign in_ack     = st_q == S_HS && hs_in_valid_i && hs_in_ack_i;
	// the bank owned by usb is never written by the cpu
	assign fw_wr_ok   = link.fw_valid && link.fw_op == OP_FIFO_WR &&
	                    !rdy_q[fe][wb] && !rx_we &&
	                    cnt_q[fe][wb] < EP_SIZE[fe];

	// command acceptance
	always_comb begin
		case (link.fw_op)
			OP_FIFO_WR:   fw_ok_d = fw_wr_ok;
			OP_SET_TXRDY: fw_ok_d = !rdy_q[fe][wb];
			default:      fw_ok_d = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// usb side sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_q       <= S_IDLE;
			cur_ep_q   <= 2'h0;
			cur_bank_q <= 1'b0;
			is_setup_q <= 1'b0;
			idx_q      <= 7'h00;
			tx_start_o <= 1'b0;
			tx_data1_o <= 1'b0;
			tx_len_o   <= 7'h00;
			tx_valid_o <= 1'b0;
			tx_byte_o  <= 8'h00;
			tx_last_o  <= 1'b0;
			hs_valid_o <= 1'b0;
			hs_code_o  <= HS_ACK;
		end else begin
			tx_start_o <= 1'b0;
			hs_valid_o <= 1'b0;
			case (st_q)
				S_IDLE: if (tok_valid_i) begin
					cur_ep_q   <= tok_ep_i;
					cur_bank_q <= dual_q[tok_ep_i] & usbbank_q[tok_ep_i];
					idx_q      <= 7'h00;
					is_setup_q <= tok_type_i == TOK_SETUP;
					if (tok_type_i == TOK_SETUP) begin
						st_q <= S_RX; // setup always taken
					end else if (stall_q[tok_ep_i]) begin
						hs_valid_o <= 1'b1; // abort by stall
						hs_code_o  <= HS_STALL;
					end else if (tok_type_i == TOK_OUT) begin
						if (setup_received_flag_q[tok_ep_i]) begin
							hs_valid_o <= 1'b1; // payload kept
							hs_code_o  <= HS_NAK;
						end else begin
							st_q <= S_RX;
						end
					end else if (rdy_q[tok_ep_i][dual_q[tok_ep_i] &
					                             usbbank_q[tok_ep_i]]) begin
						tx_start_o <= 1'b1; // bank owned at
						tx_data1_o <= tog_q[tok_ep_i];
						tx_len_o   <= cnt_q[tok_ep_i][dual_q[tok_ep_i] &
						                              usbbank_q[tok_ep_i]];
						st_q       <= S_TX;
					end else begin
						hs_valid_o <= 1'b1; // nothing ready
						hs_code_o  <= HS_NAK;
					end
				end
				S_RX: begin
					if (rx_we) begin
						idx_q <= idx_q + 7'h01;
					end
					if (rx_end_i) begin
						hs_valid_o <= 1'b1; // auto ack, empty out too
						hs_code_o  <= HS_ACK;
						st_q       <= S_IDLE;
					end
				end
				S_TX: if (!tx_valid_o || tx_ready_i) begin
					if (idx_q < cur_len) begin
						tx_valid_o <= 1'b1; // one byte per beat
						tx_byte_o  <= mem_q[{cur_ep_q, cur_bank_q, idx_q[5:0]}];
						tx_last_o  <= idx_q == 7'(cur_len - 7'h01);
						idx_q      <= idx_q + 7'h01;
					end else begin
						tx_valid_o <= 1'b0;
						tx_last_o  <= 1'b0;
						st_q       <= S_HS;
					end
				end
				S_HS: if (hs_in_valid_i) begin
					st_q <= S_IDLE; // no ack: bank stays ready for retry
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// payload memory, usb receive has priority
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rx_we) begin
			mem_q[{cur_ep_q, 1'b0, idx_q[5:0]}] <= rx_byte_i;
		end else if (fw_wr_ok) begin
			mem_q[{fe, wb, cnt_q[fe][wb][5:0]}] <= link.fw_wdata;
		end
	end

	// ------------------------------------------------------------
	// per-endpoint flags and bank bookkeeping; set wins over clear, save stall, which a setup clears
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tx_complete_flag_q  <= 4'h0;
			setup_received_flag_q <= 4'h0;
			stall_q   <= 4'h0;
			dual_q    <= 4'h0;
			irqen_q   <= 4'h0;
			tog_q     <= 4'h0;
			fwbank_q  <= 4'h0;
			usbbank_q <= 4'h0;
			for (int e = 0; e < NUM_EP; e++) begin
				rdy_q[e]   <= 2'h0;
				rdptr_q[e] <= 6'h00;
				cnt_q[e][0] <= 7'h00;
				cnt_q[e][1] <= 7'h00;
			end
		end else begin
			for (int e = 0; e < NUM_EP; e++) begin
				if (link.fw_valid && fe == 2'(e)) begin
					case (link.fw_op)
						OP_CLR_TX_COMPLETE_FLAG:  tx_complete_flag_q[e]  <= 1'b0;
						OP_CLR_SETUP_RECEIVED_FLAG: setup_received_flag_q[e] <= 1'b0;
						OP_SET_STALL:   stall_q[e]   <= 1'b1;
						OP_CLR_STALL:   stall_q[e]   <= 1'b0;
						OP_FIFO_RD:     rdptr_q[e]   <= rdptr_q[e] + 6'h01;
						OP_SET_CFG: begin
							dual_q[e]  <= link.fw_wdata[0] & DUAL_CAP[e];
							irqen_q[e] <= link.fw_wdata[1];
						end
						OP_SET_TXRDY: if (!rdy_q[e][wb]) begin
							rdy_q[e][wb] <= 1'b1;
							fwbank_q[e]  <= fwbank_q[e] ^ dual_q[e];
						end
						OP_FIFO_WR: if (fw_wr_ok) begin
							cnt_q[e][wb] <= cnt_q[e][wb] + 7'h01;
						end
						default: ;
					endcase
				end
				if (setup_done && cur_ep_q == 2'(e)) begin
					setup_received_flag_q[e] <= 1'b1;
					stall_q[e]   <= 1'b0;
					tog_q[e]     <= 1'b1; // next stage starts data1
					rdptr_q[e]   <= 6'h00;
				end
				if (in_ack && cur_ep_q == 2'(e)) begin
					tx_complete_flag_q[e]  <= 1'b1;
					tog_q[e]     <= ~tog_q[e];
					rdy_q[e][cur_bank_q]  <= 1'b0; // release to cpu
					cnt_q[e][cur_bank_q]  <= 7'h00;
					usbbank_q[e] <= usbbank_q[e] ^ dual_q[e];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// answers and status toward the controller
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fw_rvalid_q <= 1'b0;
			fw_ok_q     <= 1'b0;
			fw_rdata_q  <= 8'h00;
			st_txrdy_q  <= 4'h0;
			st_irq_q    <= 4'h0;
		end else begin
			fw_rvalid_q <= link.fw_valid;
			fw_ok_q     <= fw_ok_d;
			fw_rdata_q  <= mem_q[{fe, 1'b0, rdptr_q[fe]}];
			for (int e = 0; e < NUM_EP; e++) begin
				st_txrdy_q[e] <= |rdy_q[e];
				// pending while a flag stands, gated per endpoint
				st_irq_q[e]   <= irqen_q[e] & (setup_received_flag_q[e] | tx_complete_flag_q[e]);
			end
		end
	end

	assign link.fw_rvalid  = fw_rvalid_q;
	assign link.fw_ok      = fw_ok_q;
	assign link.fw_rdata   = fw_rdata_q;
	assign link.st_txrdy   = st_txrdy_q;
	assign link.st_tx_complete_flag  = tx_complete_flag_q;
	assign link.st_setup_received_flag = setup_received_flag_q;
	assign link.st_irq     = st_irq_q;
	assign link.st_dual    = dual_q;

endmodule : ep_txn_dev

// *** design/ep_fw_ctl.sv ***
// firmware-side controller: apb slave turning commands into link orders
// assumes an apb master on clock_i and the endpoint logic on the link
`timescale 1ns/100ps
module ep_fw_ctl (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	ep_link_if.ctl_mp         link,
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [11:0]  paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic [31:0]       prdata_o,
	output logic              pready_o,
	output logic              pslverr_o
);
	import usb_ep_pkg::*;

	typedef enum {C_IDLE, C_WAIT} ctl_st_e;

	ctl_st_e     st_q;
	logic        fw_valid_q;
	op_e         fw_op_q;
	logic [1:0]  fw_ep_q;
	logic [7:0]  fw_wdata_q;
	logic [7:0]  rdata_q;
	logic        refused_q;

	// ------------------------------------------------------------
	// command decode and firmware-side checks
	// ------------------------------------------------------------
	op_e        c_op;
	logic [1:0] c_ep;
	logic       access, refuse;
	logic [31:0] stat_word;

	assign c_op   = op_e'(pwdata_i[CMD_OP_LSB +: 3]);
	assign c_ep   = pwdata_i[CMD_EP_LSB +: 2];
	assign access = psel_i && penable_i && !pready_o;

	always_comb begin
		case (c_op)
			// control on single bank, iso and fast bulk on dual
			OP_SET_CFG:    refuse = pwdata_i[0] & !DUAL_CAP[c_ep];
			// single bank loads only when ready is clear
			OP_FIFO_WR:    refuse = !link.st_dual[c_ep] & link.st_txrdy[c_ep];
			// bit 0 marks the final packet else next ready first
			OP_CLR_TX_COMPLETE_FLAG: refuse = !pwdata_i[0] & !link.st_txrdy[c_ep];
			default:       refuse = 1'b0;
		endcase
	end

	// busy at bit 16, per-endpoint packet-ready just above it
	assign stat_word = {11'h000, link.st_txrdy, st_q == C_WAIT,
	                    link.st_irq, link.st_dual,
	                    link.st_setup_received_flag, link.st_tx_complete_flag};

	// ------------------------------------------------------------
	// apb slave with one wait state, longer while a command runs
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_q       <= C_IDLE;
			fw_valid_q <= 1'b0;
			fw_op_q    <= OP_FIFO_RD;
			fw_ep_q    <= 2'h0;
			fw_wdata_q <= 8'h00;
			rdata_q    <= 8'h00;
			refused_q  <= 1'b0;
			prdata_o   <= RESET_WORD;
			pready_o   <= 1'b0;
			pslverr_o  <= 1'b0;
		end else begin
			pready_o   <= 1'b0;
			fw_valid_q <= 1'b0;
			case (st_q)
				C_IDLE: if (access) begin
					pslverr_o <= 1'b0;
					prdata_o  <= RESET_WORD;
					if (pwrite_i && paddr_i == CMD_OFS) begin
						if (refuse) begin
							refused_q <= 1'b1;
							pready_o  <= 1'b1;
						end else begin
							// byte writes and ready marking go out here
							fw_valid_q <= 1'b1;
							fw_op_q    <= c_op;
							fw_ep_q    <= c_ep;
							fw_wdata_q <= pwdata_i[7:0];
							st_q       <= C_WAIT;
						end
					end else begin
						pready_o <= 1'b1;
						if (paddr_i == STAT_OFS) begin
							prdata_o <= stat_word;
						end else if (paddr_i == RDATA_OFS) begin
							prdata_o <= {23'h00_0000, refused_q, rdata_q};
						end else if (paddr_i != CMD_OFS) begin
							pslverr_o <= 1'b1;
						end
					end
				end
				C_WAIT: if (link.fw_rvalid) begin
					rdata_q   <= link.fw_rdata; // setup bytes read here
					refused_q <= !link.fw_ok;
					pready_o  <= 1'b1;
					st_q      <= C_IDLE;
				end
				default: st_q <= C_IDLE;
			endcase
		end
	end

	assign link.fw_valid = fw_valid_q;
	assign link.fw_op    = fw_op_q;
	assign link.fw_ep    = fw_ep_q;
	assign link.fw_wdata = fw_wdata_q;

endmodule : ep_fw_ctl

// *** tb/ep_link_assertions.sv ***
// checker of the link between firmware controller and endpoint logic
// assumes the bench wires every link signal but fw_ok and fw_rdata, plus clock_i and rst_i
`timescale 1ns/100ps
module ep_link_assertions (
	input wire logic            clock_i,
	input wire logic            rst_i,
	input wire logic            fw_valid,
	input wire usb_ep_pkg::op_e fw_op,
	input wire logic [1:0]      fw_ep,
	input wire logic [7:0]      fw_wdata,
	input wire logic            fw_rvalid,
	input wire logic [3:0]      st_txrdy,
	input wire logic [3:0]      st_tx_complete_flag,
	input wire logic [3:0]      st_setup_received_flag,
	input wire logic [3:0]      st_irq,
	input wire logic [3:0]      st_dual
);
	import usb_ep_pkg::*;

	logic [1:0] cmd_ep_q;

	// ----------
	// helpers
	// ----------
	// endpoint of the last command, for checks a few cycles on
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			cmd_ep_q <= 2'h0;
		else if (fw_valid)
			cmd_ep_q <= fw_ep;
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// ----------
	// properties
	// ----------
	property p_answer;
		fw_valid |=> fw_rvalid;
	endproperty
	a_answer: assert property (p_answer)
		else $error("command got no answer");
	property p_irq_cause;
		(st_irq & ~(st_setup_received_flag | st_tx_complete_flag | $past(st_setup_received_flag | st_tx_complete_flag)))
			== 4'h0;
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without a pending flag");
	property p_dual_cap;
		(st_dual & ~DUAL_CAP) == 4'h0;
	endproperty
	a_dual_cap: assert property (p_dual_cap)
		else $error("two banks on a single-bank endpoint");
	property p_no_dual_cmd;
		fw_valid && fw_op == OP_SET_CFG && !DUAL_CAP[fw_ep] |-> !fw_wdata[0];
	endproperty
	a_no_dual_cmd: assert property (p_no_dual_cmd)
		else $error("dual config sent to control endpoint");
	property p_ready_marks;
		fw_valid && fw_op == OP_SET_TXRDY |-> ##[1:3] st_txrdy[cmd_ep_q];
	endproperty
	a_ready_marks: assert property (p_ready_marks)
		else $error("packet ready not shown");
	property p_clr_setup;
		fw_valid && fw_op == OP_CLR_SETUP_RECEIVED_FLAG |-> ##[1:3] !st_setup_received_flag[cmd_ep_q];
	endproperty
	a_clr_setup: assert property (p_clr_setup)
		else $error("setup flag not cleared");
	property p_clr_comp;
		fw_valid && fw_op == OP_CLR_TX_COMPLETE_FLAG |-> ##[1:3] !st_tx_complete_flag[cmd_ep_q];
	endproperty
	a_clr_comp: assert property (p_clr_comp)
		else $error("complete flag not cleared");
	property p_clr_after_ready;
		fw_valid && fw_op == OP_CLR_TX_COMPLETE_FLAG && !fw_wdata[0] |-> st_txrdy[fw_ep];
	endproperty
	a_clr_after_ready: assert property (p_clr_after_ready)
		else $error("complete cleared before next ready");
	property p_fifo_guard;
		fw_valid && fw_op == OP_FIFO_WR && !st_dual[fw_ep] |-> !st_txrdy[fw_ep];
	endproperty
	a_fifo_guard: assert property (p_fifo_guard)
		else $error("fifo write into a ready single bank");

	c_setup: cover property ($rose(st_setup_received_flag[0]));
	c_comp: cover property ($rose(st_tx_complete_flag[1]));
	c_dual: cover property (st_dual[1] && st_txrdy[1]);
endmodule : ep_link_assertions

// *** tb/tb.sv ***
// self-checking bench: apb firmware side and usb token side of the pair
// assumes package, link interface and both design ends compiled first
`timescale 1ns/100ps
module tb;
	import usb_ep_pkg::*;

	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        tok_valid_i = 1'b0;
	tok_e        tok_type_i = TOK_SETUP;
	logic [1:0]  tok_ep_i = 2'h0;
	logic        rx_valid_i = 1'b0;
	logic [7:0]  rx_byte_i = 8'h00;
	logic        rx_end_i = 1'b0;
	logic        tx_ready_i = 1'b0;
	logic        hs_in_valid_i = 1'b0;
	logic        hs_in_ack_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic        tx_start_o, tx_data1_o, tx_valid_o, tx_last_o;
	logic        hs_valid_o, pready_o, pslverr_o, apb_err, pid_seen;
	logic [6:0]  tx_len_o, len_seen;
	logic [7:0]  tx_byte_o;
	logic [31:0] prdata_o;
	hs_e         hs_code_o, last_hs;
	int          hs_n = 0;
	int          done_n = 0;
	int          n_errors = 0;
	int          samples_checked = 0;
	logic [7:0]  txq [$];
	logic [7:0]  expq [$];

	ep_link_if lk ();
	ep_txn_dev i_ep_txn_dev (.clock_i, .rst_i, .link(lk), .tok_valid_i,
		.tok_type_i, .tok_ep_i, .rx_valid_i, .rx_byte_i, .rx_end_i,
		.tx_ready_i, .hs_in_valid_i, .hs_in_ack_i, .tx_start_o, .tx_data1_o,
		.tx_len_o, .tx_valid_o, .tx_byte_o, .tx_last_o, .hs_valid_o,
		.hs_code_o);
	ep_fw_ctl i_ep_fw_ctl (.clock_i, .rst_i, .link(lk), .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
	ep_link_assertions i_ep_link_assertions (.clock_i, .rst_i,
		.fw_valid(lk.fw_valid), .fw_op(lk.fw_op), .fw_ep(lk.fw_ep),
		.fw_wdata(lk.fw_wdata), .fw_rvalid(lk.fw_rvalid),
		.st_txrdy(lk.st_txrdy), .st_tx_complete_flag(lk.st_tx_complete_flag),
		.st_setup_received_flag(lk.st_setup_received_flag), .st_irq(lk.st_irq), .st_dual(lk.st_dual));

	// ----------
	// clock, sink and monitor
	// ----------
	// clock of 4 ns period
	always #2 clock_i = ~clock_i;
	// data sink stalls at random
	always @(posedge clock_i) tx_ready_i <= ($urandom_range(3, 0) != 0);
	// record handshakes and the outgoing stream
	always @(posedge clock_i) begin
		if (hs_valid_o) begin
			hs_n <= hs_n + 1;
			last_hs <= hs_code_o;
		end
		if (tx_start_o) begin
			len_seen <= tx_len_o;
			pid_seen <= tx_data1_o;
		end
		if (tx_start_o && tx_len_o == 7'h00) done_n <= done_n + 1;
		if (tx_valid_o && tx_ready_i) begin
			txq.push_back(tx_byte_o);
			if (tx_last_o) done_n <= done_n + 1;
		end
	end

	// ----------
	// tasks
	// ----------
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) check("bus answer", pready_o, 1'b1);
		r = prdata_o;
		apb_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		apb(1'b0, a, 32'h0000_0000, r);
	endtask : rd

	task automatic cmd(input op_e op, input logic [1:0] ep, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, CMD_OFS, {18'h0_0000, ep, 1'b0, op, d}, r);
	endtask : cmd

	task automatic token(input tok_e t, input logic [1:0] ep);
		@(posedge clock_i);
		tok_valid_i <= 1'b1;
		tok_type_i <= t;
		tok_ep_i <= ep;
		@(posedge clock_i);
		tok_valid_i <= 1'b0;
	endtask : token

	task automatic wait_hs(input int h, input hs_e code);
		int n;
		n = 0;
		while (hs_n == h && n < 40) begin
			@(posedge clock_i);
			n++;
		end
		check("handshake", (hs_n == h) ? 32'h0000_00ee : last_hs, code);
	endtask : wait_hs

	task automatic load(input logic [1:0] ep, input int n);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			expq.push_back(b);
			cmd(OP_FIFO_WR, ep, b);
		end
	endtask : load

	task automatic in_txn(input logic [1:0] ep, input int len, input logic pid);
		int d, n;
		d = done_n;
		n = 0;
		token(TOK_IN, ep);
		while (done_n == d && n < 300) begin
			@(posedge clock_i);
			n++;
		end
		hs_in_valid_i <= 1'b1;
		hs_in_ack_i <= 1'b1;
		@(posedge clock_i);
		hs_in_valid_i <= 1'b0;
		check("packet ended", done_n != d, 1'b1);
		check("packet length", len_seen, len);
		check("data pid", pid_seen, pid);
		check("bytes sent", txq.size(), len);
		for (int i = 0; i < len && txq.size() > 0; i++)
			check("payload byte", txq.pop_front(), expq.pop_front());
		repeat (2) @(posedge clock_i);
		check("complete flag", lk.st_tx_complete_flag[ep], 1'b1);
	endtask : in_txn

	function automatic logic [11:0] stat_exp(input logic [3:0] tc, rs, du);
		return {du, rs, tc};
	endfunction : stat_exp

	// ----------
	// main sequence
	// ----------
	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clock_i);
		n_errors++;
		test_done();
	end

	// tests in order, each building on the endpoint state left before
	initial begin
		logic [31:0] r;
		logic [7:0]  sq [8];
		int          h, nb;
		int          nl [3];
		void'($urandom(32'h3220_f7b2));
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		cmd(OP_SET_STALL, 2'h0, 8'h00);
		h = hs_n;
		token(TOK_IN, 2'h0);
		wait_hs(h, HS_STALL);
		foreach (sq[i]) sq[i] = 8'($urandom);
		h = hs_n;
		token(TOK_SETUP, 2'h0);
		foreach (sq[i]) begin
			rx_valid_i <= 1'b1;
			rx_byte_i <= sq[i];
			@(posedge clock_i);
		end
		rx_valid_i <= 1'b0;
		rx_end_i <= 1'b1;
		@(posedge clock_i);
		rx_end_i <= 1'b0;
		wait_hs(h, HS_ACK);
		check("setup flag", lk.st_setup_received_flag, 4'h1);
		check("irq masked", lk.st_irq, 4'h0);
		cmd(OP_SET_CFG, 2'h0, 8'h03);
		rd(RDATA_OFS, r);
		check("dual on ep0", {r[8], lk.st_dual}, 5'h10);
		cmd(OP_SET_CFG, 2'h0, 8'h02);
		check("irq enabled", lk.st_irq, 4'h1);
		h = hs_n;
		token(TOK_OUT, 2'h0);
		wait_hs(h, HS_NAK);
		foreach (sq[i]) begin
			cmd(OP_FIFO_RD, 2'h0, 8'h00);
			rd(RDATA_OFS, r);
			check("setup byte", r[7:0], sq[i]);
		end
		rd(STAT_OFS, r);
		check("status word", r[11:0], stat_exp(4'h0, 4'h1, 4'h0));
		rd(12'h00c, r);
		check("unmapped error", apb_err, 1'b1);
		cmd(OP_CLR_SETUP_RECEIVED_FLAG, 2'h0, 8'h00);
		check("setup cleared", {lk.st_setup_received_flag, lk.st_irq}, 8'h00);
		$display("test setup stage done");
		cmd(OP_SET_TXRDY, 2'h0, 8'h00);
		in_txn(2'h0, 0, 1'b1);
		check("irq on complete", lk.st_irq, 4'h1);
		cmd(OP_CLR_TX_COMPLETE_FLAG, 2'h0, 8'h01);
		check("complete cleared", lk.st_tx_complete_flag, 4'h0);
		h = hs_n;
		token(TOK_OUT, 2'h0);
		rx_end_i <= 1'b1;
		@(posedge clock_i);
		rx_end_i <= 1'b0;
		wait_hs(h, HS_ACK);
		check("empty out", lk.st_setup_received_flag, 4'h0);
		cmd(OP_SET_STALL, 2'h3, 8'h00);
		cmd(OP_CLR_STALL, 2'h3, 8'h00);
		h = hs_n;
		token(TOK_IN, 2'h3);
		wait_hs(h, HS_NAK);
		$display("test status stage done");
		nb = $urandom_range(8, 1);
		load(2'h3, nb);
		cmd(OP_SET_TXRDY, 2'h3, 8'h00);
		cmd(OP_FIFO_WR, 2'h3, 8'h5a);
		rd(RDATA_OFS, r);
		check("write while ready", r[8], 1'b1);
		rd(STAT_OFS, r);
		check("ready status", r[STAT_TXRDY +: 4], 4'h8);
		cmd(OP_SET_TXRDY, 2'h3, 8'h00);
		rd(RDATA_OFS, r);
		check("ready twice", r[8], 1'b1);
		in_txn(2'h3, nb, 1'b0);
		cmd(OP_CLR_TX_COMPLETE_FLAG, 2'h3, 8'h01);
		$display("test single bank done");
		cmd(OP_SET_CFG, 2'h1, 8'h01);
		check("dual config", lk.st_dual, 4'h2);
		foreach (nl[k]) nl[k] = $urandom_range(8, (k == 2) ? 0 : 1);
		load(2'h1, nl[0]);
		cmd(OP_SET_TXRDY, 2'h1, 8'h00);
		load(2'h1, nl[1]);
		rd(RDATA_OFS, r);
		check("fill second bank", r[8], 1'b0);
		in_txn(2'h1, nl[0], 1'b0);
		cmd(OP_SET_TXRDY, 2'h1, 8'h00);
		cmd(OP_CLR_TX_COMPLETE_FLAG, 2'h1, 8'h00);
		load(2'h1, nl[2]);
		rd(RDATA_OFS, r);
		check("third payload", r[8], 1'b0);
		in_txn(2'h1, nl[1], 1'b1);
		cmd(OP_SET_TXRDY, 2'h1, 8'h00);
		cmd(OP_CLR_TX_COMPLETE_FLAG, 2'h1, 8'h00);
		in_txn(2'h1, nl[2], 1'b0);
		cmd(OP_CLR_TX_COMPLETE_FLAG, 2'h1, 8'h01);
		check("all released", {lk.st_txrdy, lk.st_tx_complete_flag}, 8'h00);
		$display("test dual bank done");
		test_done();
	end
endmodule : tb
